/* core/sgc_pkg.sv */
// constants, field layout and reset values of the global switch configuration bank
//==============================================================================
// Overview of operation
// [R1] three station address bytes, reset all ones
// [R2] 14-bit payload limit 0x07D0, longer frames truncated
// [R3] limit accepts values up to 9000 bytes; code stores larger values as written, no clamp
// [R4] provider tag type 0x9100: untagged default, outer tag
// [R5] ring tag type 0x892F recognises, builds ring frames
// [R6] shaper credit counts gap, preamble when set
// [R7] policer credit counts gap, preamble when set
// [R8] vlan forwarding only while master enable set
// [R9] software fills vlan table before enabling
// [R10] invalid vid dropped when set, else host
// [R11] unknown vid forwarding beats invalid vid drop
// [R12] age count field loaded on entry update
// [R13] aging time from age count and period
// [R14] reserved multicast table consulted only when enabled
// [R15] hash select 00/11 indexes by low ten bits
// [R16] hash select 01 crc, 10 xor
// [R17] reserved read-only bits read zero, ignore writes
package sgc_pkg;

    //==========================================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] SGC_IDX_ADDR_BYTE3  = 10'h305;
    localparam logic [9:0] SGC_IDX_ADDR_BYTE4  = 10'h306;
    localparam logic [9:0] SGC_IDX_ADDR_BYTE5  = 10'h307;
    localparam logic [9:0] SGC_IDX_MAX_PAYLOAD = 10'h308;
    localparam logic [9:0] SGC_IDX_PROV_TAG    = 10'h30a;
    localparam logic [9:0] SGC_IDX_RING_TAG    = 10'h30c;
    localparam logic [9:0] SGC_IDX_CREDIT_SEL  = 10'h30e;
    localparam logic [9:0] SGC_IDX_LOOKUP_CTL0 = 10'h310;

    //==========================================================================
    // reset values
    localparam logic [7:0]  SGC_RST_ADDR_BYTE   = 8'hff;
    localparam logic [15:0] SGC_RST_MAX_PAYLOAD = 16'h07d0;
    localparam logic [15:0] SGC_RST_PROV_TAG    = 16'h9100;
    localparam logic [15:0] SGC_RST_RING_TAG    = 16'h892f;
    localparam logic [1:0]  SGC_RST_CREDIT_SEL  = 2'h3;
    localparam logic [7:0]  SGC_RST_LOOKUP_CTL0 = 8'h61;

    //==========================================================================
    // field positions
    localparam int SGC_PAYLOAD_MSB   = 13;
    localparam int SGC_SHAPER_BIT    = 1;
    localparam int SGC_POLICER_BIT   = 0;
    localparam int SGC_VLAN_EN_BIT   = 7;
    localparam int SGC_DROP_VID_BIT  = 6;
    localparam int SGC_AGE_MSB       = 5;
    localparam int SGC_AGE_LSB       = 3;
    localparam int SGC_RSVD_MC_BIT   = 2;
    localparam int SGC_HASH_MSB      = 1;

    //==========================================================================
    // counts and codes
    localparam logic [15:0] SGC_JUMBO_PAYLOAD = 16'h2328;
    localparam logic [15:0] SGC_GAP_PREAMBLE  = 16'h0014;
    localparam logic [9:0]  SGC_CRC_POLY      = 10'h233;
    localparam logic [1:0]  SGC_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  SGC_RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        SGC_HASH_DIRECT,
        SGC_HASH_CRC,
        SGC_HASH_XOR,
        SGC_HASH_DIRECT_ALT
    } sgc_hash_type;

endpackage : sgc_pkg

/* core/sgc_regs.sv */
// global switch configuration registers with axi4-lite slave and dependent logic
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sgc_regs (
    input  wire logic        aclk,              // clock
    input  wire logic        aresetn,           // sync reset, low
    input  wire logic [11:0] s_axi_awaddr,      // aw address
    input  wire logic        s_axi_awvalid,     // aw valid
    output var  logic        s_axi_awready,     // aw ready
    input  wire logic [31:0] s_axi_wdata,       // w data
    input  wire logic [3:0]  s_axi_wstrb,       // w strobes
    input  wire logic        s_axi_wvalid,      // w valid
    output var  logic        s_axi_wready,      // w ready
    output var  logic [1:0]  s_axi_bresp,       // b response
    output var  logic        s_axi_bvalid,      // b valid
    input  wire logic        s_axi_bready,      // b ready
    input  wire logic [11:0] s_axi_araddr,      // ar address
    input  wire logic        s_axi_arvalid,     // ar valid
    output var  logic        s_axi_arready,     // ar ready
    output var  logic [31:0] s_axi_rdata,       // r data
    output var  logic [1:0]  s_axi_rresp,       // r response
    output var  logic        s_axi_rvalid,      // r valid
    input  wire logic        s_axi_rready,      // r ready
    output var  logic [23:0] station_addr_low,  // address bits 23..0
    input  wire logic        frame_valid,       // frame strobe
    input  wire logic [15:0] frame_payload_len, // payload length
    output var  logic        frame_out_valid,   // frame result
    output var  logic [15:0] frame_out_len,     // cut length
    output var  logic        frame_truncated,   // frame cut
    input  wire logic        double_tag_active, // double tagging
    input  wire logic        ingress_untagged,  // untagged frame
    input  wire logic [15:0] rx_ether_type,     // ether type
    output var  logic        tag_insert,        // insert tag
    output var  logic [15:0] tag_insert_type,   // inserted type
    output var  logic        ring_tag_hit,      // ring tagged
    output var  logic [15:0] ring_tag_type_out, // ring tag type
    input  wire logic        credit_valid,      // credit strobe
    input  wire logic [13:0] credit_data_bytes, // data bytes
    output var  logic        credit_out_valid,  // credit result
    output var  logic [15:0] shaper_deduct,     // shaper credit
    output var  logic [15:0] policer_deduct,    // policer credit
    input  wire logic        vid_check,         // vid strobe
    input  wire logic        vid_invalid,       // vid invalid
    input  wire logic        unknown_vid_fwd,   // unknown vid fwd
    output var  logic        vlan_mode,         // vlan active
    output var  logic        vid_drop,          // drop packet
    output var  logic        vid_to_host,       // to host port
    input  wire logic        entry_update,      // entry updated
    output var  logic        age_load,          // age load
    output var  logic [2:0]  age_load_value,    // age to load
    input  wire logic [7:0]  age_period,        // age period
    output var  logic [10:0] aging_time,        // count x period
    input  wire logic        lookup_req,        // lookup strobe
    input  wire logic [47:0] lookup_dest_addr,  // dest address
    output var  logic        lookup_out_valid,  // lookup result
    output var  logic [9:0]  table_index,       // table index
    output var  logic        rsvd_mc_consult    // reserved table
);
    import sgc_pkg::*;

    //==========================================================================
    // decode helpers
    function automatic logic [3:0] reg_sel(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        if (addr[1:0] != 2'h0)
            reg_sel = 4'h0;
        else if (idx == SGC_IDX_ADDR_BYTE3)
            reg_sel = 4'h1;
        else if (idx == SGC_IDX_ADDR_BYTE4)
            reg_sel = 4'h2;
        else if (idx == SGC_IDX_ADDR_BYTE5)
            reg_sel = 4'h3;
        else if (idx == SGC_IDX_MAX_PAYLOAD)
            reg_sel = 4'h4;
        else if (idx == SGC_IDX_PROV_TAG)
            reg_sel = 4'h5;
        else if (idx == SGC_IDX_RING_TAG)
            reg_sel = 4'h6;
        else if (idx == SGC_IDX_CREDIT_SEL)
            reg_sel = 4'h7;
        else if (idx == SGC_IDX_LOOKUP_CTL0)
            reg_sel = 4'h8;
        else
            reg_sel = 4'h0;
    endfunction : reg_sel

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16[7:0]  = strb[0] ? data[7:0] : old[7:0];
        merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    endfunction : merge16

    // serial crc over the address, lsb first
    function automatic logic [9:0] crc_hash(input logic [47:0] addr);
        logic [9:0] crc;
        logic       fb;
        crc = 10'h000;
        for (int i = 0; i < 48; i++) begin
            fb  = crc[9] ^ addr[i];
            crc = {crc[8:0], 1'b0} ^ (fb ? SGC_CRC_POLY : 10'h000);
        end
        crc_hash = crc;
    endfunction : crc_hash

    //==========================================================================
    // registers
    logic [7:0]  addr_byte3;
    logic [7:0]  addr_byte4;
    logic [7:0]  addr_byte5;
    logic [15:0] max_frame_payload_length;
    logic [15:0] provider_tag_type;
    logic [15:0] ring_tag_type;
    logic [1:0]  credit_select;
    logic [7:0]  lookup_ctl0;

    //==========================================================================
    // write channel
    logic        aw_full;
    logic [11:0] aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire         aw_take      = s_axi_awvalid & s_axi_awready;
    wire         w_take       = s_axi_wvalid & s_axi_wready;
    wire         do_write     = aw_full & w_full & ~s_axi_bvalid;
    wire  [3:0]  wr_sel       = reg_sel(aw_addr);
    wire         next_aw_full = aw_take | (aw_full & ~do_write);
    wire         next_w_full  = w_take | (w_full & ~do_write);
    wire         next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SGC_RESP_OKAY;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= ~next_aw_full & ~next_bvalid;
            s_axi_wready  <= ~next_w_full & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= (wr_sel == 4'h0) ? SGC_RESP_SLVERR : SGC_RESP_OKAY;
            end
        end
    end

    // jumbo limits stored as written
    wire [15:0] wr_payload = merge16(max_frame_payload_length, w_data, w_strb); // R3

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_byte3               <= SGC_RST_ADDR_BYTE; // R1
            addr_byte4               <= SGC_RST_ADDR_BYTE; // R1
            addr_byte5               <= SGC_RST_ADDR_BYTE; // R1
            max_frame_payload_length <= SGC_RST_MAX_PAYLOAD; // R2
            provider_tag_type        <= SGC_RST_PROV_TAG; // R4
            ring_tag_type            <= SGC_RST_RING_TAG; // R5
            credit_select            <= SGC_RST_CREDIT_SEL;
            lookup_ctl0              <= SGC_RST_LOOKUP_CTL0;
        end else if (do_write && w_strb[0]) begin
            unique case (wr_sel)
                4'h1: addr_byte3 <= w_data[7:0]; // R1
                4'h2: addr_byte4 <= w_data[7:0]; // R1
                4'h3: addr_byte5 <= w_data[7:0]; // R1
                4'h4: max_frame_payload_length <= wr_payload;
                4'h5: provider_tag_type <= merge16(provider_tag_type, w_data, w_strb);
                4'h6: ring_tag_type <= merge16(ring_tag_type, w_data, w_strb);
                4'h7: credit_select <= w_data[1:0]; // R17
                4'h8: lookup_ctl0 <= w_data[7:0];
                default: ;
            endcase
        end else if (do_write && w_strb[1]) begin
            // upper byte alone only touches the 16-bit registers
            unique case (wr_sel)
                4'h4: max_frame_payload_length <= wr_payload;
                4'h5: provider_tag_type <= merge16(provider_tag_type, w_data, w_strb);
                4'h6: ring_tag_type <= merge16(ring_tag_type, w_data, w_strb);
                default: ;
            endcase
        end
    end

    //==========================================================================
    // read channel
    wire         ar_take     = s_axi_arvalid & s_axi_arready;
    wire  [3:0]  rd_sel      = reg_sel(s_axi_araddr);
    wire         next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_sel)
            4'h1: rd_word[7:0]  = addr_byte3;
            4'h2: rd_word[7:0]  = addr_byte4;
            4'h3: rd_word[7:0]  = addr_byte5;
            4'h4: rd_word[15:0] = max_frame_payload_length;
            4'h5: rd_word[15:0] = provider_tag_type;
            4'h6: rd_word[15:0] = ring_tag_type;
            4'h7: rd_word[1:0]  = credit_select; // R17
            4'h8: rd_word[7:0]  = lookup_ctl0;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= SGC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_sel == 4'h0) ? SGC_RESP_SLVERR : SGC_RESP_OKAY;
            end
        end
    end

    //==========================================================================
    // field views
    wire [13:0]   payload_limit = max_frame_payload_length[SGC_PAYLOAD_MSB:0];
    wire          shaper_full   = credit_select[SGC_SHAPER_BIT];
    wire          policer_full  = credit_select[SGC_POLICER_BIT];
    wire          vlan_en       = lookup_ctl0[SGC_VLAN_EN_BIT];
    wire          drop_inv_vid  = lookup_ctl0[SGC_DROP_VID_BIT];
    wire [2:0]    age_count     = lookup_ctl0[SGC_AGE_MSB:SGC_AGE_LSB];
    wire          rsvd_mc_en    = lookup_ctl0[SGC_RSVD_MC_BIT];
    sgc_hash_type hash_sel;
    assign hash_sel = sgc_hash_type'(lookup_ctl0[SGC_HASH_MSB:0]);

    //==========================================================================
    // frame length limit
    wire        too_long = frame_payload_len > {2'b00, payload_limit}; // R2
    wire [15:0] cut_len  = too_long ? {2'b00, payload_limit} : frame_payload_len;

    //==========================================================================
    // tag selection
    wire need_outer = ingress_untagged | double_tag_active; // R4
    wire ring_match = rx_ether_type == ring_tag_type; // R5

    //==========================================================================
    // credit accounting
    wire [15:0] data_bytes  = {2'b00, credit_data_bytes};
    wire [15:0] with_gap    = data_bytes + SGC_GAP_PREAMBLE;

    //==========================================================================
    // vlan decision: unknown vid forwarding wins
    wire inv_drop    = vlan_en & vid_invalid & ~unknown_vid_fwd & drop_inv_vid; // R10 R11
    wire inv_to_host = vlan_en & vid_invalid & (unknown_vid_fwd | ~drop_inv_vid); // R10 R11

    //==========================================================================
    // table index
    logic [9:0] xor_index;
    always_comb begin
        xor_index = lookup_dest_addr[9:0] ^ lookup_dest_addr[19:10]
                  ^ lookup_dest_addr[29:20] ^ lookup_dest_addr[39:30]
                  ^ {2'b00, lookup_dest_addr[47:40]};
    end

    logic [9:0] next_index;
    always_comb begin
        unique case (hash_sel)
            SGC_HASH_CRC:        next_index = crc_hash(lookup_dest_addr); // R16
            SGC_HASH_XOR:        next_index = xor_index; // R16
            SGC_HASH_DIRECT,
            SGC_HASH_DIRECT_ALT: next_index = lookup_dest_addr[9:0]; // R15
        endcase
    end

    // reserved multicast block 01-80-c2-00-00-xx
    wire rsvd_mc_addr = lookup_dest_addr[47:8] == 40'h01_80c2_0000;

    //==========================================================================
    // outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            station_addr_low  <= {3{SGC_RST_ADDR_BYTE}};
            frame_out_valid   <= 1'b0;
            frame_out_len     <= 16'h0000;
            frame_truncated   <= 1'b0;
            tag_insert        <= 1'b0;
            tag_insert_type   <= SGC_RST_PROV_TAG;
            ring_tag_hit      <= 1'b0;
            ring_tag_type_out <= SGC_RST_RING_TAG;
            credit_out_valid  <= 1'b0;
            shaper_deduct     <= 16'h0000;
            policer_deduct    <= 16'h0000;
            vlan_mode         <= 1'b0;
            vid_drop          <= 1'b0;
            vid_to_host       <= 1'b0;
            age_load          <= 1'b0;
            age_load_value    <= 3'h0;
            aging_time        <= 11'h000;
            lookup_out_valid  <= 1'b0;
            table_index       <= 10'h000;
            rsvd_mc_consult   <= 1'b0;
        end else begin
            station_addr_low  <= {addr_byte3, addr_byte4, addr_byte5}; // R1
            frame_out_valid   <= frame_valid;
            if (frame_valid) begin
                frame_out_len   <= cut_len; // R2
                frame_truncated <= too_long; // R2
            end
            tag_insert        <= need_outer; // R4
            tag_insert_type   <= provider_tag_type; // R4
            ring_tag_hit      <= ring_match; // R5
            ring_tag_type_out <= ring_tag_type; // R5
            credit_out_valid  <= credit_valid;
            if (credit_valid) begin
                shaper_deduct  <= shaper_full ? with_gap : data_bytes; // R6
                policer_deduct <= policer_full ? with_gap : data_bytes; // R7
            end
            vlan_mode         <= vlan_en; // R8
            vid_drop          <= vid_check & inv_drop; // R10
            vid_to_host       <= vid_check & inv_to_host; // R11
            age_load          <= entry_update; // R12
            if (entry_update) begin
                age_load_value <= age_count; // R12
            end
            aging_time        <= age_count * age_period; // R13
            lookup_out_valid  <= lookup_req;
            if (lookup_req) begin
                table_index     <= next_index;
                rsvd_mc_consult <= rsvd_mc_en & rsvd_mc_addr; // R14
            end
        end
    end

endmodule : sgc_regs
`default_nettype wire

/* bench/sgc_regs_properties.sv */
// concurrent checks on the global switch configuration register block
`timescale 1ns/1ps
`default_nettype none
module sgc_regs_properties (
    input wire logic        aclk,              // clock
    input wire logic        aresetn,           // reset, low
    input wire logic        s_axi_arvalid,     // ar valid
    input wire logic        s_axi_arready,     // ar ready
    input wire logic        s_axi_rvalid,      // r valid
    input wire logic        s_axi_rready,      // r ready
    input wire logic        frame_valid,       // frame strobe
    input wire logic [15:0] frame_payload_len, // length in
    input wire logic        frame_out_valid,   // frame result
    input wire logic [15:0] frame_out_len,     // cut length
    input wire logic        frame_truncated,   // frame cut
    input wire logic        vid_check,         // vid strobe
    input wire logic        vid_invalid,       // vid invalid
    input wire logic        unknown_vid_fwd,   // unknown fwd
    input wire logic        vid_drop,          // drop
    input wire logic        vid_to_host,       // to host
    input wire logic        entry_update,      // entry strobe
    input wire logic        age_load           // age strobe
);
    //==========================================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_frame_answer: assert property (frame_valid |=> frame_out_valid)
        else $error("frame result strobe missing");
    a_frame_cut_len: assert property (frame_valid |=> frame_out_len <= $past(frame_payload_len)
        && frame_truncated == (frame_out_len != $past(frame_payload_len)))
        else $error("truncated length or flag wrong");
    a_vid_has_cause: assert property ((vid_drop || vid_to_host)
        |-> $past(vid_check) && $past(vid_invalid)) else $error("vid result without cause");
    a_vid_one_way: assert property (!(vid_drop && vid_to_host))
        else $error("vid both dropped and forwarded");
    a_unknown_wins: assert property (vid_check && unknown_vid_fwd |=> !vid_drop)
        else $error("drop despite unknown vid forwarding");
    a_age_load_seen: assert property (entry_update |=> age_load)
        else $error("age load strobe missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped before taken");
endmodule : sgc_regs_properties

bind sgc_regs sgc_regs_properties i_sgc_regs_properties (.*);
`default_nettype wire

/* bench/tb_sgc_regs.sv */
// self-checking bench for the global switch configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_sgc_regs;
    import sgc_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} sgc_row_type;
    logic        aclk, aresetn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_rvalid, frame_valid, frame_out_valid, frame_truncated, double_tag_active;
    logic        ingress_untagged, tag_insert, ring_tag_hit, credit_valid, credit_out_valid;
    logic        vid_check, vid_invalid, unknown_vid_fwd, vlan_mode, vid_drop, vid_to_host;
    logic        entry_update, age_load, lookup_req, lookup_out_valid, rsvd_mc_consult;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] frame_payload_len, frame_out_len, rx_ether_type, tag_insert_type;
    logic [15:0] ring_tag_type_out, shaper_deduct, policer_deduct;
    logic [23:0] station_addr_low;
    logic [13:0] credit_data_bytes;
    logic [2:0]  age_load_value;
    logic [7:0]  age_period;
    logic [10:0] aging_time;
    logic [47:0] lookup_dest_addr;
    logic [9:0]  table_index;
    logic [31:0] rst_e [8] = '{8'hff, 8'hff, 8'hff, 16'h07d0, 16'h9100, 16'h892f, 2'h3, 8'h61};
    int          error_cnt, n_compared, cyc;
    sgc_row_type rows [8] = '{'{12'hc14, 32'h12, 32'h12}, '{12'hc18, 32'h34, 32'h34},
        '{12'hc1c, 32'h56, 32'h56}, '{12'hc20, 32'h2328, 32'h2328},
        '{12'hc28, 32'h88a8, 32'h88a8}, '{12'hc30, 32'h1234, 32'h1234},
        '{12'hc38, 32'hffff, 32'h0003}, '{12'hc40, 32'had, 32'had}};

    sgc_regs i_sgc_regs (.*);

    //==========================================================================
    // shared tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // strobe one cycle, look after answer
    task automatic pulse(input logic [4:0] m);
        @(posedge aclk);
        {frame_valid, credit_valid, vid_check, entry_update, lookup_req} <= m;
        @(posedge aclk);
        {frame_valid, credit_valid, vid_check, entry_update, lookup_req} <= 5'h00;
        #1;
    endtask : pulse
    task automatic stop_test();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    //==========================================================================
    // clock and timeout
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    //==========================================================================
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {frame_valid, credit_valid, vid_check, entry_update, lookup_req} = '0;
        {double_tag_active, ingress_untagged, vid_invalid, unknown_vid_fwd} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frame_payload_len, rx_ether_type} = '0;
        {credit_data_bytes, age_period, lookup_dest_addr} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            chk("bresp", SGC_RESP_OKAY, resp);
            rd(rows[i].a);
            chk("rdata", rows[i].e, rd_data);
        end
        chk("station", 24'h12_3456, station_addr_low);
        ingress_untagged <= 1'b1;
        rx_ether_type    <= 16'h1234;
        repeat (2) @(posedge aclk);
        #1;
        chk("tag", {1'b1, 16'h88a8}, {tag_insert, tag_insert_type});
        chk("ring", {1'b1, 16'h1234}, {ring_tag_hit, ring_tag_type_out});
        wr(12'hc20, 32'h0100);
        for (int n = 16'h0101; n >= 16'h0100; n--) begin
            frame_payload_len <= n[15:0];
            pulse(5'h10);
            chk("frame", {1'b1, n == 16'h0101, 16'h0100},
                {frame_out_valid, frame_truncated, frame_out_len});
        end
        credit_data_bytes <= 14'd100;
        pulse(5'h08);
        chk("credit_valid", 1'b1, credit_out_valid);
        chk("credit", {16'd120, 16'd120}, {shaper_deduct, policer_deduct});
        wr(12'hc38, 32'h2);
        pulse(5'h08);
        chk("credit", {16'd120, 16'd100}, {shaper_deduct, policer_deduct});
        vid_invalid <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(12'hc40, (k == 3 ? 32'h6d : 32'had) | (k == 1 || k == 2 ? 32'h40 : 32'h0));
            unknown_vid_fwd <= (k == 2);
            pulse(5'h04);
            chk("vid", (k == 1) ? 2'b10 : (k == 3) ? 2'b00 : 2'b01, {vid_drop, vid_to_host});
        end
        chk("vlan", 1'b0, vlan_mode);
        age_period <= 8'd3;
        pulse(5'h02);
        chk("age", {1'b1, 3'd5, 11'd15}, {age_load, age_load_value, aging_time});
        lookup_dest_addr <= 48'h0180_c200_0003;
        for (int h = 0; h < 4; h++) begin
            wr(12'hc40, 32'h6c | h);
            pulse(5'h01);
            chk("rsvd", 2'b11, {lookup_out_valid, rsvd_mc_consult});
            if (h != 1) chk("index", (h == 2) ? 10'h221 : 10'h003, table_index);
        end
        wr(12'hc40, 32'h69);
        pulse(5'h01);
        chk("rsvd", 1'b0, rsvd_mc_consult);
        rd(12'hc24);
        chk("unmapped", SGC_RESP_SLVERR, resp);
        chk("unmapped", 32'h0, rd_data);
        wr(12'hc24, 32'h5);
        chk("unmapped", SGC_RESP_SLVERR, resp);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_e[k]) begin
            rd(rows[k].a);
            chk("reset", rst_e[k], rd_data);
        end
        chk("station", 24'hff_ffff, station_addr_low);
        stop_test();
    end
endmodule : tb_sgc_regs
`default_nettype wire
